// ---- verilog/ls_unit_map.svh ----
// Field positions and fixed offsets of the single load/store unit
`ifndef LS_UNIT_MAP_SVH
`define LS_UNIT_MAP_SVH

// ==========================================================
// Instruction fields
`define F_COND     31:28
`define F_CLASS    27:26
`define F_IREG     25
`define F_PRE      24
`define F_UP       23
`define F_BYTE     22
`define F_WB       21
`define F_LOAD     20
`define F_RN       19:16
`define F_RD       15:12
`define F_IMM      11:0
`define F_SAMT     11:7
`define F_STYP     6:5
`define F_SREG     4
`define F_RM       3:0
`define CLASS_SDT  2'h1

// ==========================================================
// Flag positions in i_flags
`define FLG_N      3
`define FLG_Z      2
`define FLG_C      1
`define FLG_V      0

// ==========================================================
// Program counter handling
`define PC_IDX        4'hf
`define PC_BASE_OFS   32'h8
`define PC_STORE_OFS  32'hc
`define IMM_PAD       20'h0

`endif

// ---- verilog/ls_unit_pkg.sv ----
// Types of the single load/store unit
package ls_unit_pkg;

	// ==========================================================
	// Sequencer states, bus cycle kinds, shift types and condition codes
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_FETCH   = 3'b001,
		S_DATA    = 3'b010,
		S_INT     = 3'b011,
		S_REFILL1 = 3'b100,
		S_REFILL2 = 3'b101
	} state_t;

	typedef enum logic [1:0] {
		CYC_NONE  = 2'b00,
		CYC_FETCH = 2'b01,
		CYC_DATA  = 2'b10,
		CYC_INT   = 2'b11
	} cyc_t;

	typedef enum logic [1:0] {
		SH_LSL = 2'b00,
		SH_LSR = 2'b01,
		SH_ASR = 2'b10,
		SH_ROR = 2'b11
	} shift_t;

	typedef enum logic [3:0] {
		C_EQ = 4'b0000, C_NE = 4'b0001, C_CS = 4'b0010, C_CC = 4'b0011,
		C_MI = 4'b0100, C_PL = 4'b0101, C_VS = 4'b0110, C_VC = 4'b0111,
		C_HI = 4'b1000, C_LS = 4'b1001, C_GE = 4'b1010, C_LT = 4'b1011,
		C_GT = 4'b1100, C_LE = 4'b1101, C_AL = 4'b1110, C_NV = 4'b1111
	} cond_t;

	// ==========================================================
	// Sequencer state record
	typedef struct packed {
		state_t      state;
		logic [31:0] ins;
		logic [31:0] iaddr;
		logic [31:0] base;
		logic [31:0] wb;
		logic        wb_en;
		logic [31:0] ld;
		logic        abort;
		logic        mem_req;
		logic        mem_wr;
		logic        mem_byte;
		logic        mem_user;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		cyc_t        cyc;
		logic        busy;
		logic        done;
		logic        data_abort;
		logic        undef;
		logic        pc_load;
		logic [31:0] pc_new;
	} core_t;

endpackage : ls_unit_pkg

// ---- verilog/rf_if.sv ----
// Register bank access bundle between sequencer and bank
`timescale 1ns/1ps

interface rf_if #(
	parameter int DW  = 32,
	parameter int AW  = 4,
	parameter int NRD = 4
);
	logic [NRD-1:0][AW-1:0] raddr;
	logic [NRD-1:0][DW-1:0] rdata;
	logic                   we;
	logic [AW-1:0]          waddr;
	logic [DW-1:0]          wdata;

	modport core (output raddr, output we, output waddr, output wdata, input rdata);
	modport bank (input raddr, input we, input waddr, input wdata, output rdata);
endinterface : rf_if

// ---- verilog/ls_reg_bank.sv ----
// Register bank with registered read ports and one write port
`timescale 1ns/1ps

module ls_reg_bank #(
	parameter int DW  = 32,
	parameter int AW  = 4,
	parameter int NRD = 4
) (
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	rf_if.bank        rf
);
	typedef struct packed {
		logic [(1<<AW)-1:0][DW-1:0] mem;
		logic [NRD-1:0][DW-1:0]     rd;
	} bank_t;

	bank_t cur_ff;
	bank_t nxt_bank;

	// ==========================================================
	// Read before write: a read in the write cycle sees old data
	always_comb begin
		nxt_bank = cur_ff;
		for (int i = 0; i < NRD; i++) begin
			nxt_bank.rd[i] = cur_ff.mem[rf.raddr[i]];
		end
		if (rf.we) begin
			nxt_bank.mem[rf.waddr] = rf.wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cur_ff <= '0;
		end else if (i_ce) begin
			cur_ff <= nxt_bank;
		end
	end

	for (genvar g = 0; g < NRD; g++) begin : g_rd
		assign rf.rdata[g] = cur_ff.rd[g];
	end
endmodule : ls_reg_bank

// ---- verilog/ls_unit.sv ----
// Single load/store execution unit: addressing, lane steering, sequencing
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ls_unit_map.svh"

// Operation
// RL1: Run only when condition field passes current flags, else no operation.
// RL2: Offset is 12-bit unsigned immediate or optionally shifted register.
// RL3: Up bit set adds offset to base, clear subtracts it.
// RL4: Pre bit set uses modified base as address, clear uses old base.
// RL5: Pre-indexed write-back bit selects whether modified base is stored.
// RL6: Post-indexed transfers always write the modified base back.
// RL7: Post-indexed with write-back bit forces non-privileged memory cycle.
// RL8: Register offset uses immediate shift only; register shift amounts unsupported.
// RL9: Byte bit selects byte transfer, clear selects word transfer.
// RL10: Little endian byte load takes lane by address, zero-extended.
// RL11: Byte store repeats low byte on all four lanes.
// RL12: Little endian unaligned word load rotates addressed byte to bits 7..0.
// RL13: Big endian byte load takes lane from top downward, zero-extended.
// RL14: Big endian word load at offset 0 or 2 puts byte at 31..24.
// RL15: Word store drives register unrotated whatever the alignment.
// RL16: Program counter as base reads instruction address plus eight.
// RL17: Program counter stored by word store gives instruction address plus twelve.
// RL18: Software never writes back a PC base nor uses PC as offset.
// RL19: Software never post-indexes with offset register equal to base.
// RL20: With late aborts the base is updated before the abort handler.
// RL21: Memory abort on a transfer is reported as a data abort.
// RL22: Load takes fetch, read, internal; PC load adds two refill fetches.
// RL23: Store takes one fetch then one data write.
// RL24: Big endian word load at offset 1 or 3 rotates likewise.
// RL25: Internal lane positions stay as for 32-bit memory with 16-bit memory.
module ls_unit #(
	parameter int DW = 32,
	parameter int AW = 4
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	input  wire logic          i_ce,
	input  wire logic          i_instr_valid,
	input  wire logic [31:0]   i_instr,
	input  wire logic [31:0]   i_instr_addr,
	input  wire logic [3:0]    i_flags,
	input  wire logic          i_priv,
	input  wire logic          i_big_endian,
	input  wire logic          i_late_abort,
	input  wire logic [31:0]   i_mem_rdata,
	input  wire logic          i_mem_abort,
	input  wire logic [AW-1:0] i_reg_addr,
	input  wire logic [DW-1:0] i_reg_wdata,
	input  wire logic          i_reg_wr,
	input  wire logic          i_reg_rd,
	output logic               o_busy,
	output logic [1:0]         o_cyc,
	output logic               o_mem_req,
	output logic               o_mem_wr,
	output logic               o_mem_byte,
	output logic               o_mem_user,
	output logic [31:0]        o_mem_addr,
	output logic [31:0]        o_mem_wdata,
	output logic               o_done,
	output logic               o_data_abort,
	output logic               o_undef,
	output logic               o_pc_load,
	output logic [31:0]        o_pc_new,
	output logic [DW-1:0]      o_reg_rdata
);
	ls_unit_pkg::core_t cur_ff;
	ls_unit_pkg::core_t nxt_core;

	rf_if #(.DW(DW), .AW(AW), .NRD(4)) rf ();

	ls_reg_bank #(.DW(DW), .AW(AW), .NRD(4)) u_bank (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.rf      (rf.bank)
	);

	// ==========================================================
	// Helpers
	function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
		logic n;
		logic z;
		logic cy;
		logic v;
		n  = f[`FLG_N];
		z  = f[`FLG_Z];
		cy = f[`FLG_C];
		v  = f[`FLG_V];
		case (ls_unit_pkg::cond_t'(c))
			ls_unit_pkg::C_EQ: cond_pass = z;
			ls_unit_pkg::C_NE: cond_pass = !z;
			ls_unit_pkg::C_CS: cond_pass = cy;
			ls_unit_pkg::C_CC: cond_pass = !cy;
			ls_unit_pkg::C_MI: cond_pass = n;
			ls_unit_pkg::C_PL: cond_pass = !n;
			ls_unit_pkg::C_VS: cond_pass = v;
			ls_unit_pkg::C_VC: cond_pass = !v;
			ls_unit_pkg::C_HI: cond_pass = cy && !z;
			ls_unit_pkg::C_LS: cond_pass = !cy || z;
			ls_unit_pkg::C_GE: cond_pass = (n == v);
			ls_unit_pkg::C_LT: cond_pass = (n != v);
			ls_unit_pkg::C_GT: cond_pass = !z && (n == v);
			ls_unit_pkg::C_LE: cond_pass = z || (n != v);
			ls_unit_pkg::C_AL: cond_pass = 1'b1;
			default:           cond_pass = 1'b0;
		endcase
	endfunction : cond_pass

	// Amount zero encodes the 32-place and extended-rotate forms
	function automatic logic [31:0] shift_imm(input logic [31:0] val, input logic [1:0] typ,
		input logic [4:0] amt, input logic cin);
		logic [5:0] back;
		back = 6'h20 - {1'b0, amt};
		case (ls_unit_pkg::shift_t'(typ))
			ls_unit_pkg::SH_LSL: shift_imm = val << amt;
			ls_unit_pkg::SH_LSR: shift_imm = (amt == 5'h0) ? 32'h0 : val >> amt;
			ls_unit_pkg::SH_ASR: shift_imm = (amt == 5'h0) ? {32{val[31]}}
				: 32'($signed(val) >>> amt);
			ls_unit_pkg::SH_ROR: shift_imm = (amt == 5'h0) ? {cin, val[31:1]}
				: ((val >> amt) | (val << back));
			default:             shift_imm = val;
		endcase
	endfunction : shift_imm

	// Lane numbering is that of the internal bus even behind 16-bit memory
	function automatic logic [31:0] load_align(input logic [31:0] raw, input logic [1:0] a,
		input logic byte_op, input logic be);
		logic [1:0]  lane;
		logic [63:0] dbl;
		logic [5:0]  sh;
		lane = be ? ~a : a;
		dbl  = {raw, raw};
		sh   = {a, 3'h0};
		if (byte_op) begin
			load_align = {24'h0, raw[{lane, 3'h0} +: 8]};
		end else if (be) begin
			load_align = 32'((dbl << sh) >> 32);
		end else begin
			load_align = 32'(dbl >> sh);
		end
	endfunction : load_align

	// ==========================================================
	// Datapath
	logic [31:0] ins_w;
	logic [3:0]  rn;
	logic [3:0]  rd;
	logic [31:0] base_v;
	logic [31:0] off_v;
	logic [31:0] mod_v;
	logic [31:0] src_v;
	logic        post;
	logic        bad_op;

	assign ins_w = cur_ff.ins;
	assign rn    = ins_w[`F_RN];
	assign rd    = ins_w[`F_RD];
	assign post  = !ins_w[`F_PRE];
	// RL16 pc base plus eight
	assign base_v = (rn == `PC_IDX) ? cur_ff.iaddr + `PC_BASE_OFS : rf.rdata[0];
	// RL2 immediate or shifted register
	assign off_v  = ins_w[`F_IREG]
		? shift_imm(rf.rdata[1], ins_w[`F_STYP], ins_w[`F_SAMT], i_flags[`FLG_C])
		: {`IMM_PAD, ins_w[`F_IMM]};
	// RL3 add or subtract offset
	assign mod_v  = ins_w[`F_UP] ? base_v + off_v : base_v - off_v;
	// RL17 pc stored as address plus twelve
	assign src_v  = (rd == `PC_IDX) ? cur_ff.iaddr + `PC_STORE_OFS : rf.rdata[2];
	// RL8 register-specified shift amounts rejected
	assign bad_op = (ins_w[`F_CLASS] != `CLASS_SDT) || (ins_w[`F_IREG] && ins_w[`F_SREG]);

	// ==========================================================
	// Sequencer
	always_comb begin
		nxt_core            = cur_ff;
		nxt_core.done       = 1'b0;
		nxt_core.data_abort = 1'b0;
		nxt_core.undef      = 1'b0;
		nxt_core.pc_load    = 1'b0;
		nxt_core.mem_req    = 1'b0;
		nxt_core.mem_wr     = 1'b0;
		rf.we               = 1'b0;
		rf.waddr            = rn;
		rf.wdata            = cur_ff.wb;
		if (cur_ff.state == ls_unit_pkg::S_IDLE) begin
			rf.raddr[0] = i_instr[`F_RN];
			rf.raddr[1] = i_instr[`F_RM];
			rf.raddr[2] = i_instr[`F_RD];
		end else begin
			rf.raddr[0] = rn;
			rf.raddr[1] = ins_w[`F_RM];
			rf.raddr[2] = rd;
		end
		rf.raddr[3] = i_reg_addr;
		case (cur_ff.state)
			ls_unit_pkg::S_IDLE: begin
				nxt_core.cyc = ls_unit_pkg::CYC_NONE;
				if (i_instr_valid) begin
					nxt_core.ins   = i_instr;
					nxt_core.iaddr = i_instr_addr;
					nxt_core.abort = 1'b0;
					nxt_core.state = ls_unit_pkg::S_FETCH;
					nxt_core.cyc   = ls_unit_pkg::CYC_FETCH;
					nxt_core.busy  = 1'b1;
				end
			end
			ls_unit_pkg::S_FETCH: begin
				nxt_core.base  = base_v;
				nxt_core.wb    = mod_v;
				// RL5 RL6 write-back choice; RL18 pc base never written back
				nxt_core.wb_en = (post || ins_w[`F_WB]) && (rn != `PC_IDX);
				// RL1 failed condition ends as no operation
				if (!cond_pass(ins_w[`F_COND], i_flags) || bad_op) begin
					nxt_core.undef = cond_pass(ins_w[`F_COND], i_flags);
					nxt_core.state = ls_unit_pkg::S_IDLE;
					nxt_core.cyc   = ls_unit_pkg::CYC_NONE;
					nxt_core.busy  = 1'b0;
					nxt_core.done  = 1'b1;
				end else begin
					nxt_core.state    = ls_unit_pkg::S_DATA;
					nxt_core.cyc      = ls_unit_pkg::CYC_DATA;
					nxt_core.mem_req  = 1'b1;
					nxt_core.mem_wr   = !ins_w[`F_LOAD];
					// RL9 byte or word transfer
					nxt_core.mem_byte = ins_w[`F_BYTE];
					// RL7 forced user access
					nxt_core.mem_user = !i_priv || (post && ins_w[`F_WB]);
					// RL4 pre uses modified base
					nxt_core.mem_addr = post ? base_v : mod_v;
					// RL11 RL15 byte replicated, word unrotated
					nxt_core.mem_wdata = ins_w[`F_BYTE] ? {4{src_v[7:0]}} : src_v;
				end
			end
			ls_unit_pkg::S_DATA: begin
				// RL21 memory abort captured
				nxt_core.abort = i_mem_abort;
				// RL10 RL12 RL13 RL14 RL24 RL25 lane steering and rotation
				nxt_core.ld    = load_align(i_mem_rdata, cur_ff.mem_addr[1:0],
					ins_w[`F_BYTE], i_big_endian);
				// RL20 late abort keeps base update
				if (cur_ff.wb_en && (!i_mem_abort || i_late_abort)) begin
					rf.we = 1'b1;
				end
				// RL22 RL23 load adds internal cycle
				if (ins_w[`F_LOAD]) begin
					nxt_core.state = ls_unit_pkg::S_INT;
					nxt_core.cyc   = ls_unit_pkg::CYC_INT;
				end else begin
					nxt_core.state      = ls_unit_pkg::S_IDLE;
					nxt_core.cyc        = ls_unit_pkg::CYC_NONE;
					nxt_core.busy       = 1'b0;
					nxt_core.done       = 1'b1;
					nxt_core.data_abort = i_mem_abort;
				end
			end
			ls_unit_pkg::S_INT: begin
				if (!cur_ff.abort) begin
					rf.we    = 1'b1;
					rf.waddr = rd;
					rf.wdata = cur_ff.ld;
				end
				// RL22 pc load refills pipeline
				if (!cur_ff.abort && (rd == `PC_IDX)) begin
					nxt_core.pc_load = 1'b1;
					nxt_core.pc_new  = cur_ff.ld;
					nxt_core.state   = ls_unit_pkg::S_REFILL1;
					nxt_core.cyc     = ls_unit_pkg::CYC_FETCH;
				end else begin
					nxt_core.state      = ls_unit_pkg::S_IDLE;
					nxt_core.cyc        = ls_unit_pkg::CYC_NONE;
					nxt_core.busy       = 1'b0;
					nxt_core.done       = 1'b1;
					nxt_core.data_abort = cur_ff.abort;
				end
			end
			ls_unit_pkg::S_REFILL1: begin
				nxt_core.state = ls_unit_pkg::S_REFILL2;
				nxt_core.cyc   = ls_unit_pkg::CYC_FETCH;
			end
			ls_unit_pkg::S_REFILL2: begin
				nxt_core.state = ls_unit_pkg::S_IDLE;
				nxt_core.cyc   = ls_unit_pkg::CYC_NONE;
				nxt_core.busy  = 1'b0;
				nxt_core.done  = 1'b1;
			end
			default: begin
				nxt_core.state = ls_unit_pkg::S_IDLE;
				nxt_core.cyc   = ls_unit_pkg::CYC_NONE;
				nxt_core.busy  = 1'b0;
			end
		endcase
		// Software write loses to a core write in the same cycle
		if (!rf.we && i_reg_wr) begin
			rf.we    = 1'b1;
			rf.waddr = i_reg_addr;
			rf.wdata = i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cur_ff <= '0;
		end else if (i_ce) begin
			cur_ff <= nxt_core;
		end
	end

	assign o_busy       = cur_ff.busy;
	assign o_cyc        = cur_ff.cyc;
	assign o_mem_req    = cur_ff.mem_req;
	assign o_mem_wr     = cur_ff.mem_wr;
	assign o_mem_byte   = cur_ff.mem_byte;
	assign o_mem_user   = cur_ff.mem_user;
	assign o_mem_addr   = cur_ff.mem_addr;
	assign o_mem_wdata  = cur_ff.mem_wdata;
	assign o_done       = cur_ff.done;
	assign o_data_abort = cur_ff.data_abort;
	assign o_undef      = cur_ff.undef;
	assign o_pc_load    = cur_ff.pc_load;
	assign o_pc_new     = cur_ff.pc_new;
	assign o_reg_rdata  = rf.rdata[3];

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk iff i_ce); endclocking
	default disable iff (!i_rst_b);

	logic in_fetch;
	logic in_data;
	logic cpass;
	assign in_fetch = cur_ff.state == ls_unit_pkg::S_FETCH;
	assign in_data  = cur_ff.state == ls_unit_pkg::S_DATA;
	assign cpass    = cond_pass(ins_w[`F_COND], i_flags);

	a_cond_noop: assert property (in_fetch && !cpass |=> !o_mem_req && !o_busy && o_done) // RL1
		else $error("failed condition still made an access");
	a_post_addr: assert property (in_data && post |-> o_mem_addr == cur_ff.base) // RL4
		else $error("post-indexed address is not the old base");
	a_imm_updown: assert property (in_fetch && cpass && !bad_op && !ins_w[`F_IREG] // RL3
		|=> o_mem_addr == (ins_w[`F_UP] ? $past(base_v) + {`IMM_PAD, ins_w[`F_IMM]}
			: $past(base_v) - {`IMM_PAD, ins_w[`F_IMM]}) || post)
		else $error("immediate offset applied wrongly");
	a_user_force: assert property (o_mem_req && post && ins_w[`F_WB] |-> o_mem_user) // RL7
		else $error("post-indexed write-back not user cycle");
	a_byte_repl: assert property (o_mem_req && o_mem_wr && o_mem_byte // RL11
		|-> o_mem_wdata == {4{o_mem_wdata[7:0]}})
		else $error("byte store lanes differ");
	a_post_wb: assert property (in_data && post && rn != `PC_IDX && !i_mem_abort // RL6
		|-> rf.we && rf.waddr == rn && rf.wdata == cur_ff.wb)
		else $error("post-indexed base not written back");
	a_late_wb: assert property (in_data && cur_ff.wb_en && i_mem_abort && i_late_abort // RL20
		|-> rf.we && rf.waddr == rn)
		else $error("late abort lost base update");
	a_abort_flag: assert property (in_data && i_mem_abort |-> ##[1:2] o_data_abort) // RL21
		else $error("abort not reported");
	a_load_cycles: assert property (in_fetch && cpass && !bad_op && ins_w[`F_LOAD] // RL22
		|=> o_cyc == ls_unit_pkg::CYC_DATA ##1 o_cyc == ls_unit_pkg::CYC_INT)
		else $error("load cycle order wrong");
	a_store_cycles: assert property (in_fetch && cpass && !bad_op && !ins_w[`F_LOAD] // RL23
		|=> o_mem_wr ##1 o_done && !o_busy)
		else $error("store did not end after its write");
	a_pc_refill: assert property (o_pc_load |-> o_cyc == ls_unit_pkg::CYC_FETCH // RL22
		##1 o_cyc == ls_unit_pkg::CYC_FETCH ##1 o_done)
		else $error("pc load refill wrong");

	c_load: cover property (o_mem_req && !o_mem_wr ##1 o_cyc == ls_unit_pkg::CYC_INT);
	c_store: cover property (o_mem_req && o_mem_wr && o_mem_byte);
	c_abort: cover property (o_data_abort);
	c_pc_load: cover property (o_pc_load);
endmodule : ls_unit

// ---- verif/ls_mem_model.sv ----
// Memory system model answering the data cycles of the load/store unit
`timescale 1ns/1ps

module ls_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_mem_req,
	input  wire logic [31:0] i_mem_addr,
	input  wire logic        i_abort_cmd,
	output logic [31:0]      o_rdata,
	output logic             o_abort
);
	logic [31:0] last_ff = 32'h0;
	logic [7:0]  b;

	// Fixed pattern per word, so every lane is predictable
	assign b = {i_mem_addr[7:2], 2'b00};
	// Off-cycle data flips each clock, a stale sample never matches
	assign o_rdata = i_mem_req ? {~b, b + 8'h11, b ^ 8'h3c, b} : ~last_ff;
	assign o_abort = i_mem_req & i_abort_cmd;

	always_ff @(posedge i_clk) begin
		last_ff <= o_rdata;
	end
endmodule : ls_mem_model

// ---- verif/load_store_addressing_unit_tb_top.sv ----
// Self-checking bench of the single load/store unit
`timescale 1ns/1ps

module load_store_addressing_unit_tb_top;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_instr_valid = 1'b0;
	logic [31:0] i_instr = 32'h0;
	logic [31:0] i_instr_addr = 32'h0;
	logic [3:0]  i_flags = 4'h0;
	logic        i_priv = 1'b0;
	logic        i_big_endian = 1'b0;
	logic        i_late_abort = 1'b0;
	logic [3:0]  i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic        abort_cmd = 1'b0;
	logic [31:0] i_mem_rdata, o_mem_addr, o_mem_wdata, o_pc_new, o_reg_rdata;
	logic        i_mem_abort, o_busy, o_mem_req, o_mem_wr, o_mem_byte, o_mem_user;
	logic        o_done, o_data_abort, o_undef, o_pc_load;
	logic [1:0]  o_cyc;
	logic [31:0] regs [16];
	logic [31:0] seed = 32'd23205;
	int          n_errors = 0;
	int          comparisons = 0;

	ls_unit DUT (.i_ce(1'b1), .*);
	ls_mem_model MEM (.i_clk(i_clk), .i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr),
		.i_abort_cmd(abort_cmd), .o_rdata(i_mem_rdata), .o_abort(i_mem_abort));

	always #25 i_clk = ~i_clk;

	// ========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] mword(input logic [31:0] a);
		logic [7:0] b;
		b = {a[7:2], 2'b00};
		return {~b, b + 8'h11, b ^ 8'h3c, b};
	endfunction : mword

	function automatic logic [31:0] shf(input logic [31:0] v, input logic [4:0] a,
		input logic [1:0] t, input logic c);
		case (t)
			2'h0: return v << a;
			2'h1: return (a == 5'h0) ? 32'h0 : v >> a;
			2'h2: return (a == 5'h0) ? {32{v[31]}} : 32'($signed(v) >>> a);
			default: return (a == 5'h0) ? {c, v[31:1]} : (v >> a) | (v << (6'd32 - a));
		endcase
	endfunction : shf

	function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] & ~f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = ~f[2] & (f[3] == f[0]);
			default: r = 1'b1;
		endcase
		return r ^ c[0];
	endfunction : cpass

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	task automatic chk_regs();
		for (int r = 0; r < 15; r++) begin
			@(posedge i_clk);
			i_reg_rd <= 1'b1;
			i_reg_addr <= 4'(r);
			@(posedge i_clk);
			i_reg_rd <= 1'b0;
			@(negedge i_clk);
			chk(o_reg_rdata, regs[r], "register");
		end
	endtask : chk_regs

	// Bits: flags 3:0, priv 4, big endian 5, late abort 6, abort 7
	task automatic cfg(input logic [31:0] r);
		@(posedge i_clk);
		i_flags <= r[3:0];
		i_priv <= r[4];
		i_big_endian <= r[5];
		i_late_abort <= r[6];
		abort_cmd <= r[7];
	endtask : cfg

	// ========================================
	// One instruction, predicted and checked
	task automatic run(input logic [31:0] ins, input logic [31:0] ia);
		logic [31:0] base, off, mdf, addr, w, ld, wd, g_addr, g_wd, g_pc;
		logic [2:0]  g_kind;
		logic [3:0]  rn, rd;
		logic        ex, und, pre, ldop, bt, wbk, pcl, g_ab, g_und, g_pcl;
		int          sh, n, nf, nd;
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_instr <= ins;
		i_instr_addr <= ia;
		rn = ins[19:16];
		rd = ins[15:12];
		pre = ins[24];
		bt = ins[22];
		ldop = ins[20];
		und = ins[27:26] != 2'h1 || (ins[25] && ins[4]);
		ex = !und && cpass(ins[31:28], i_flags);
		base = (rn == 4'hf) ? ia + 32'h8 : regs[rn];
		off = ins[25] ? shf(regs[ins[3:0]], ins[11:7], ins[6:5], i_flags[1]) : {20'h0, ins[11:0]};
		mdf = ins[23] ? base + off : base - off;
		addr = pre ? mdf : base;
		wbk = (!pre || ins[21]) && rn != 4'hf;
		w = mword(addr);
		sh = 8 * int'(addr[1:0]);
		if (bt)
			ld = (i_big_endian ? w >> (24 - sh) : w >> sh) & 32'hff;
		else
			ld = i_big_endian ? (w << sh) | (w >> (32 - sh)) : (w >> sh) | (w << (32 - sh));
		wd = (rd == 4'hf) ? ia + 32'hc : regs[rd];
		if (bt)
			wd = {4{wd[7:0]}};
		pcl = ex && ldop && rd == 4'hf && !abort_cmd;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		n = 0;
		nf = 0;
		nd = 0;
		g_pcl = 1'b0;
		do begin
			@(negedge i_clk);
			n++;
			// Pc load pulse comes before the done pulse
			if (o_pc_load === 1'b1)
				g_pcl = 1'b1;
			if (o_cyc === ls_unit_pkg::CYC_FETCH)
				nf++;
			if (o_mem_req === 1'b1) begin
				nd++;
				{g_addr, g_wd, g_kind} = {o_mem_addr, o_mem_wdata, o_mem_wr, o_mem_byte, o_mem_user};
			end
		end while (o_done !== 1'b1 && n < 20);
		{g_ab, g_und, g_pc} = {o_data_abort, o_undef, o_pc_new};
		chk(32'(n), ex ? (ldop ? (pcl ? 32'h6 : 32'h4) : 32'h3) : 32'h2, "cycles");
		chk(32'(nd), 32'(ex), "data cycles");
		chk(32'(g_und), 32'(und && cpass(ins[31:28], i_flags)), "undefined");
		if (ex) begin
			chk(32'(nf), pcl ? 32'h3 : 32'h1, "fetches");
			chk(g_addr, addr, "address");
			chk(32'(g_kind), 32'({!ldop, bt, !i_priv || (!pre && ins[21])}), "kind");
			if (!ldop) chk(g_wd, wd, "store data");
			chk(32'(g_ab), 32'(abort_cmd), "abort");
			chk(32'(g_pcl), 32'(pcl), "pc load");
			if (pcl) chk(g_pc, ld, "new pc");
			if (wbk && (!abort_cmd || i_late_abort)) regs[rn] = mdf;
			if (ldop && !abort_cmd && rd != 4'hf) regs[rd] = ld;
		end
		chk_regs();
	endtask : run

	// Offset register never the base nor the pc, base never the pc
	task automatic rand_one();
		logic [31:0] r, ins;
		r = rnd();
		ins = rnd();
		ins[27:26] = 2'h1;
		ins[19:16] = 4'(r[19:16] % 4'hf);
		ins[15:12] = 4'(ins[15:12] % 4'hf);
		ins[3:0] = 4'((32'(ins[19:16]) + 32'h1 + 32'(r[23:20] % 4'he)) % 32'hf);
		ins[4] = 1'b0;
		if (r[12])
			ins[31:28] = 4'he;
		cfg({r[31:8], r[13] & r[14] & r[15], r[6:0]});
		run(ins, rnd() & 32'hffff_fffc);
	endtask : rand_one

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// ========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int r = 0; r < 15; r++) begin
			regs[r] = (r == 1) ? 32'h100 : rnd();
			reg_wr(4'(r), regs[r]);
		end
		for (int i = 0; i < 16; i++) begin
			cfg({26'h0, i[3], 5'h10});
			run(32'he5910000 | (32'(i[2]) << 22) | 32'(i[1:0]), 32'h40);
		end
		for (int i = 0; i < 4; i++) begin
			cfg({26'h0, i[1], 5'h10});
			run(32'he5812001 | (32'(i[0]) << 22), 32'h80);
		end
		run(32'he59f0004, 32'h200);
		run(32'he581f000, 32'h204);
		run(32'he591f000, 32'h208);
		run(32'he7910012, 32'h20c);
		run(32'he1910000, 32'h210);
		run(32'he5a12004, 32'h214);
		run(32'he5212004, 32'h218);
		run(32'he4b10004, 32'h21c);
		for (int i = 0; i < 2; i++) begin
			cfg({25'h0, 1'b1, i[0], 5'h10});
			run(32'he4812004, 32'h220);
		end
		for (int i = 0; i < 8; i++) begin
			cfg(32'h12);
			run(32'he7910002 | (32'(i[1:0]) << 5) | (32'(i[2]) << 10), 32'h224);
		end
		$display("test corner cases done");
		repeat (150) rand_one();
		$display("test random done");
		close_out();
	end

	// About four and a half times the expected length of the run
	initial begin
		#1500000;
		n_errors++;
		close_out();
	end
endmodule : load_store_addressing_unit_tb_top
